// file: isv_vector_select.sv
// Function
// - Unit off: pin0 maskable, pin1 non-maskable
// - Maskable pin fetches vector over system bus
// - Non-maskable request always uses vector 2
// - Unit on: pins use programmed table vectors
// - Maskable pin accepts vectors 0 to 255
// - Unit accepts maskable vectors 16 to 255
// - Unit vectors 0-15 flag illegal vector, only while sequencer idle
// - Interrupt-enable flag gates all maskable requests
// - Software interrupt vector from operand, any
// - Soft vector 2 skips non-maskable state
// - Software interrupts ignore interrupt-enable flag
// - Software interrupt never pushes error code
// - Overflow, breakpoint, range instructions raise exceptions
// - Machine check raises vector 18, error code
// - Suspend, run handler, resume unless unrecoverable
// - Reset, flush, stop-clock, etc. bypass this path
// - Each exception fixed vector and class
// - Vectors 0-31 architectural, 32-255 user
// - Faults return to the faulting instruction
`timescale 1ns/10ps
`default_nettype none
module isv_vector_select
  import isv_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // Local request pins, asynchronous
  input wire logic [1:0] I_LOCAL_REQUEST_PINS,
  // On-chip interrupt unit enable and local table vectors
  input wire logic I_ONCHIP_UNIT_EN,
  input wire logic [7:0] I_LVT_VEC0,
  input wire logic [7:0] I_LVT_VEC1,
  // Vector message forwarded by the system interrupt router
  input wire logic I_ROUTER_VALID,
  input wire logic [7:0] I_ROUTER_VEC,
  // Vector fetch over the system bus
  output logic O_VEC_FETCH,
  input wire logic I_VEC_FETCH_ACK,
  input wire logic [7:0] I_VEC_FETCH_DATA,
  // Interrupt-enable flag of the processor flags word
  input wire logic I_IF_FLAG,
  // Software interrupt instruction
  input wire logic I_SOFT_INT,
  input wire logic [7:0] I_SOFT_VEC,
  // Software-raised exception instructions
  input wire logic [1:0] I_SW_EXC,
  // Program-error exception
  input wire logic I_EXC_VALID,
  input wire logic [7:0] I_EXC_VEC,
  // Machine-check detection
  input wire logic I_MCHK,
  // Reset and side-band interrupt pins never enter this path
  // Dispatch handshake
  output isv_dispatch_t O_DISPATCH,
  output logic O_DISPATCH_VALID,
  input wire logic I_HANDLER_DONE,
  output logic O_SUSPENDED,
  output logic O_ILLEGAL_VEC
);
  // ==========================================================
  // Pin synchronisers
  logic [1:0] pin_s1_r; // First stage only
  logic [1:0] pin_s2_r; // Second stage, read by logic
  logic [1:0] pin_q_r; // Previous value for edge detect

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_q_r <= 2'h0;
    end
    else
    begin
      pin_s1_r <= I_LOCAL_REQUEST_PINS;
      pin_s2_r <= pin_s1_r;
      pin_q_r <= pin_s2_r;
    end
  end

  // ==========================================================
  // Request decode
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_HANDLER} isv_state_t;
  isv_state_t state_r;
  isv_state_t state_nxt;

  wire unit_off = !I_ONCHIP_UNIT_EN;
  // Pin 0 maskable level, pin 1 non-maskable edge
  wire mask_pin = unit_off && pin_s2_r[0];
  wire nmi_edge = unit_off && pin_s2_r[1] && !pin_q_r[1];
  // Unit on: rising edge on either pin uses its table vector
  wire [1:0] lint_edge = pin_s2_r & ~pin_q_r;
  wire lvt0_req = I_ONCHIP_UNIT_EN && lint_edge[0];
  wire lvt1_req = I_ONCHIP_UNIT_EN && lint_edge[1];
  wire [7:0] unit_vec = I_ROUTER_VALID ? I_ROUTER_VEC :
                        (lvt0_req ? I_LVT_VEC0 : I_LVT_VEC1);
  wire unit_any = I_ROUTER_VALID || lvt0_req || lvt1_req;
  // Unit only takes vectors 16 and up
  wire unit_legal = unit_vec >= VEC_UNIT_MIN;
  wire unit_illegal = unit_any && !unit_legal;
  // One group mask for every maskable source
  wire unit_take = unit_any && unit_legal && I_IF_FLAG;
  wire pin_take = mask_pin && I_IF_FLAG;
  wire idle = state_r == ST_IDLE;
  // Software-raised exception vectors
  wire [7:0] swexc_vec = (I_SW_EXC == ISV_SW_OVERFLOW) ? VEC_OVERFLOW :
                         (I_SW_EXC == ISV_SW_BREAK) ? VEC_BREAKPOINT :
                         VEC_RANGE;
  wire swexc_req = I_SW_EXC != ISV_SW_NONE;
  // Exception vectors 0..31 index the class tables
  wire exc_arch = I_EXC_VEC <= VEC_ARCH_LAST;
  wire [4:0] exc_idx = I_EXC_VEC[4:0];
  wire exc_fault = exc_arch && FAULT_MAP[exc_idx];
  wire exc_abort = exc_arch && ABORT_MAP[exc_idx];
  wire exc_err = exc_arch && ERRCODE_MAP[exc_idx];

  // ==========================================================
  // Candidate selection, fixed order, one per event
  isv_dispatch_t cand;
  logic cand_valid;
  always_comb
  begin
    cand = '0;
    cand_valid = 1'b0;
    if (I_MCHK)
    begin
      // Abort on vector 18 with error code
      cand.vector = VEC_MACHINE_CHECK;
      cand.err_code = 1'b1;
      cand.cls = ISV_CL_ABORT;
      cand.kind = ISV_EV_MCHK;
      cand_valid = 1'b1;
    end
    else if (I_EXC_VALID)
    begin
      cand.vector = I_EXC_VEC;
      cand.err_code = exc_err;
      cand.cls = exc_fault ? ISV_CL_FAULT :
                 (exc_abort ? ISV_CL_ABORT : ISV_CL_TRAP);
      cand.restart_here = exc_fault;
      cand.kind = ISV_EV_EXC;
      cand_valid = 1'b1;
    end
    else if (swexc_req)
    begin
      // Range check is a fault, the other two are traps
      cand.vector = swexc_vec;
      cand.cls = (I_SW_EXC == ISV_SW_RANGE) ? ISV_CL_FAULT : ISV_CL_TRAP;
      cand.restart_here = I_SW_EXC == ISV_SW_RANGE;
      cand.kind = ISV_EV_EXC;
      cand_valid = 1'b1;
    end
    else if (I_SOFT_INT)
    begin
      // Operand vector, no mask, no error code, no NMI state
      cand.vector = I_SOFT_VEC;
      cand.err_code = 1'b0;
      cand.nmi_state = 1'b0;
      cand.cls = ISV_CL_MASKABLE_REQUEST_PIN;
      cand.kind = ISV_EV_SOFT;
      cand_valid = 1'b1;
    end
    else if (nmi_edge)
    begin
      // Fixed vector regardless of any bus vector
      cand.vector = VEC_NMI;
      cand.nmi_state = 1'b1;
      cand.cls = ISV_CL_MASKABLE_REQUEST_PIN;
      cand.kind = ISV_EV_NMI;
      cand_valid = 1'b1;
    end
    else if (unit_take)
    begin
      cand.vector = unit_vec;
      cand.cls = ISV_CL_MASKABLE_REQUEST_PIN;
      cand.kind = ISV_EV_EXT;
      cand_valid = 1'b1;
    end
  end

  // ==========================================================
  // Sequencer: idle, vector fetch, handler running
  wire start_fetch = idle && !cand_valid && pin_take;
  wire fetch_done = (state_r == ST_FETCH) && I_VEC_FETCH_ACK;
  wire issue = (idle && cand_valid) || fetch_done;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (cand_valid)
          state_nxt = ST_HANDLER;
        else if (start_fetch)
          state_nxt = ST_FETCH;
      ST_FETCH:
        if (I_VEC_FETCH_ACK)
          state_nxt = ST_HANDLER;
      ST_HANDLER:
        if (I_HANDLER_DONE)
          state_nxt = ST_IDLE;
    endcase
  end

  // Fetched vector: any value 0..255 accepted
  isv_dispatch_t fetched;
  always_comb
  begin
    fetched = '0;
    fetched.vector = I_VEC_FETCH_DATA;
    fetched.cls = ISV_CL_MASKABLE_REQUEST_PIN;
    fetched.kind = ISV_EV_EXT;
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      state_r <= ST_IDLE;
      O_DISPATCH <= '0;
      O_DISPATCH_VALID <= 1'b0;
      O_VEC_FETCH <= 1'b0;
      O_SUSPENDED <= 1'b0;
      O_ILLEGAL_VEC <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      O_DISPATCH_VALID <= issue;
      if (issue)
        O_DISPATCH <= fetched_sel(fetch_done, fetched, cand);
      O_VEC_FETCH <= state_nxt == ST_FETCH;
      O_SUSPENDED <= state_nxt == ST_HANDLER;
      O_ILLEGAL_VEC <= idle && unit_illegal;
    end
  end

  function automatic isv_dispatch_t fetched_sel(input logic f,
    input isv_dispatch_t a, input isv_dispatch_t b);
    fetched_sel = f ? a : b;
  endfunction : fetched_sel

  // ==========================================================
  // Checks
  nmi_vector_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_DISPATCH_VALID && O_DISPATCH.kind == ISV_EV_NMI
      |-> O_DISPATCH.vector == VEC_NMI)
    else $error("NMI dispatched on wrong vector");
  soft_noerr_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_DISPATCH_VALID && O_DISPATCH.kind == ISV_EV_SOFT
      |-> !O_DISPATCH.err_code && !O_DISPATCH.nmi_state)
    else $error("Soft interrupt carries error or NMI state");
  mask_gate_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    $rose(O_VEC_FETCH) |-> $past(I_IF_FLAG))
    else $error("Maskable fetch with flag clear");
  unit_range_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_DISPATCH_VALID && O_DISPATCH.kind == ISV_EV_EXT && !$past(fetch_done)
      |-> O_DISPATCH.vector >= VEC_UNIT_MIN)
    else $error("Unit vector below sixteen taken");
  illegal_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    idle && unit_any && !unit_legal |=> O_ILLEGAL_VEC)
    else $error("Illegal unit vector not flagged");
  mchk_vec_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    idle && I_MCHK |=> O_DISPATCH_VALID
      && O_DISPATCH.vector == VEC_MACHINE_CHECK && O_DISPATCH.err_code)
    else $error("Machine check not on vector 18");
  sequence fetch_s;
    O_VEC_FETCH ##0 I_VEC_FETCH_ACK;
  endsequence
  fetch_dispatch_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    fetch_s |=> O_DISPATCH_VALID && O_DISPATCH.vector == $past(I_VEC_FETCH_DATA))
    else $error("Fetched vector not dispatched");
  resume_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_SUSPENDED && I_HANDLER_DONE |=> !O_SUSPENDED)
    else $error("Did not resume after handler");

  // ==========================================================
  // Checks on the dispatch record and its sequencing
  // A taken event keeps the handler busy, so one pulse only
  single_issue_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_DISPATCH_VALID |=> !O_DISPATCH_VALID)
    else $error("Two dispatches for one event");
  // Every dispatch suspends the running procedure
  suspend_with_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_DISPATCH_VALID |-> O_SUSPENDED)
    else $error("Dispatch without suspension");
  // Only the pin path with the unit off may fetch
  unit_off_fetch_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    $rose(O_VEC_FETCH) |-> $past(unit_off))
    else $error("Vector fetch with unit enabled");
  // Fetch request stands until the controller answers
  fetch_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_VEC_FETCH && !I_VEC_FETCH_ACK |=> O_VEC_FETCH)
    else $error("Fetch dropped before answer");
  // Soft request with nothing stronger pending
  sequence soft_req_s;
    idle && I_SOFT_INT && !I_MCHK && !I_EXC_VALID && !swexc_req;
  endsequence
  // Soft dispatch seen on the output
  sequence soft_out_s;
    O_DISPATCH_VALID && O_DISPATCH.kind == ISV_EV_SOFT;
  endsequence
  soft_taken_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    soft_req_s |=> soft_out_s ##0 O_DISPATCH.vector == $past(I_SOFT_VEC))
    else $error("Soft interrupt not taken on its operand");
  // Breakpoint instruction with nothing stronger pending
  sequence break_req_s;
    idle && !I_MCHK && !I_EXC_VALID && I_SW_EXC == ISV_SW_BREAK;
  endsequence
  break_vec_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    break_req_s |=> O_DISPATCH_VALID && O_DISPATCH.vector == VEC_BREAKPOINT
      && O_DISPATCH.cls == ISV_CL_TRAP)
    else $error("Breakpoint not raised as a trap");
  // Non-maskable edge with nothing stronger pending
  sequence nmi_req_s;
    idle && nmi_edge && !I_MCHK && !I_EXC_VALID && !swexc_req && !I_SOFT_INT;
  endsequence
  nmi_taken_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    nmi_req_s |=> O_DISPATCH_VALID && O_DISPATCH.vector == VEC_NMI
      && O_DISPATCH.nmi_state)
    else $error("Non-maskable edge not taken");
  // Restart point follows the fault class exactly
  fault_restart_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_DISPATCH_VALID
      |-> O_DISPATCH.restart_here == (O_DISPATCH.cls == ISV_CL_FAULT))
    else $error("Restart point does not match class");
  // Exception vectors above the reserved range carry no class data
  user_trap_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_DISPATCH_VALID && O_DISPATCH.kind == ISV_EV_EXC
      && O_DISPATCH.vector > VEC_ARCH_LAST
      |-> O_DISPATCH.cls == ISV_CL_TRAP && !O_DISPATCH.err_code)
    else $error("User vector given exception class");
endmodule : isv_vector_select
`default_nettype wire

// file: isv_pkg.sv
package isv_pkg;
  // ==========================================================
  // Vector numbers
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_RANGE = 8'h05;
  localparam logic [7:0] VEC_MACHINE_CHECK = 8'h12;
  localparam logic [7:0] VEC_UNIT_MIN = 8'h10;
  localparam logic [7:0] VEC_ARCH_LAST = 8'h1F;
  // Error-code carrying exception vectors (bit per vector 0..31)
  localparam logic [31:0] ERRCODE_MAP = 32'h00027D00;
  // Fault class per exception vector 0..31 (others traps/aborts)
  localparam logic [31:0] FAULT_MAP = 32'h000B7EE3;
  localparam logic [31:0] ABORT_MAP = 32'h00040100;

  // ==========================================================
  // Event kinds and exception classes
  typedef enum logic [2:0] {
    ISV_EV_NONE,
    ISV_EV_EXT,
    ISV_EV_NMI,
    ISV_EV_SOFT,
    ISV_EV_EXC,
    ISV_EV_MCHK
  } isv_kind_t;

  typedef enum logic [1:0] {
    ISV_CL_MASKABLE_REQUEST_PIN,
    ISV_CL_FAULT,
    ISV_CL_TRAP,
    ISV_CL_ABORT
  } isv_class_t;

  // Software-raised exception instruction kinds
  typedef enum logic [1:0] {
    ISV_SW_NONE,
    ISV_SW_OVERFLOW,
    ISV_SW_BREAK,
    ISV_SW_RANGE
  } isv_swexc_t;

  // Dispatch record handed to the handler-call logic
  typedef struct packed {
    logic [7:0] vector;
    logic err_code;
    logic nmi_state;
    logic restart_here;
    isv_class_t cls;
    isv_kind_t kind;
  } isv_dispatch_t;
endpackage : isv_pkg

// file: isv_intc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Interrupt controller answering vector fetches
module isv_intc_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_fetch,
  input wire logic [7:0] i_vec,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [7:0] o_data
);
  logic [3:0] cnt_r; // Cycles waited on this fetch
  // One-cycle ack after i_delay cycles
  always_ff @(posedge i_clk)
  begin
    o_ack <= 1'h0;
    o_data <= ~o_data; // Released bus scrambles
    cnt_r <= 4'h0;
    if (i_rst)
      o_data <= 8'h5A;
    else if (i_fetch && !o_ack && cnt_r == i_delay)
    begin
      o_ack <= 1'h1;
      o_data <= i_vec;
    end
    else if (i_fetch && !o_ack)
      cnt_r <= cnt_r + 4'h1;
  end
endmodule : isv_intc_model
`default_nettype wire

// file: isv_vector_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module isv_vector_select_tb
  import isv_pkg::*;
;
  // ==========================================
  // Stimulus and observed signals
  logic clk = 1'h0, rst = 1'h1, en = 1'h0, rv = 1'h0, ifl = 1'h0;
  logic si = 1'h0, ev = 1'h0, mc = 1'h0, hd = 1'h0;
  logic [1:0] pins = 2'h0, swx = 2'h0;
  logic [7:0] lv0 = 8'h41, lv1 = 8'h27, rvec = 8'h00, sv = 8'h00;
  logic [7:0] evec = 8'h00, pvec = 8'h00, fdata;
  logic [3:0] pdel = 4'h0; // Controller answer delay
  logic fetch, ack, dv, susp, ill, i, a;
  isv_dispatch_t disp;
  int errors = 0, check_count = 0, cyc = 0;

  isv_vector_select i_dut (.I_SYS_CLK(clk), .I_RST(rst),
    .I_LOCAL_REQUEST_PINS(pins), .I_ONCHIP_UNIT_EN(en),
    .I_LVT_VEC0(lv0), .I_LVT_VEC1(lv1), .I_ROUTER_VALID(rv),
    .I_ROUTER_VEC(rvec), .O_VEC_FETCH(fetch), .I_VEC_FETCH_ACK(ack),
    .I_VEC_FETCH_DATA(fdata), .I_IF_FLAG(ifl), .I_SOFT_INT(si),
    .I_SOFT_VEC(sv), .I_SW_EXC(swx), .I_EXC_VALID(ev), .I_EXC_VEC(evec),
    .I_MCHK(mc), .O_DISPATCH(disp), .O_DISPATCH_VALID(dv),
    .I_HANDLER_DONE(hd), .O_SUSPENDED(susp), .O_ILLEGAL_VEC(ill));
  isv_intc_model i_intc (.i_clk(clk), .i_rst(rst), .i_fetch(fetch),
    .i_vec(pvec), .i_delay(pdel), .o_ack(ack), .o_data(fdata));

  // ==========================================
  // Clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Wait for dispatch, judge it, finish handler
  task automatic take(input logic [7:0] v, input logic e, input logic m);
    int n;
    n = 0;
    while (dv !== 1'h1 && n < 40)
    begin
      tick(1);
      n++;
    end
    check(disp.vector, v);
    check({6'h00, disp.err_code, disp.nmi_state}, {6'h00, e, m});
    check({7'h00, susp}, 8'h01);
    pins = 2'h0;
    tick(4);
    hd = 1'h1;
    tick(1);
    hd = 1'h0;
    check({7'h00, susp}, 8'h00);
    tick(1);
  endtask : take
  // Look for any illegal flag or activity
  task automatic watch(input int n);
    i = 1'h0;
    a = 1'h0;
    repeat (n)
    begin
      i |= ill;
      a |= dv | fetch;
      tick(1);
    end
  endtask : watch

  // ==========================================
  // Scenarios
  task automatic t_soft();
    logic [7:0] vv [5] = '{8'h00, 8'h02, 8'h0E, 8'h23, 8'hFF};
    ifl = 1'h0; // Soft ints ignore the mask
    foreach (vv[k])
    begin
      si = 1'h1;
      sv = vv[k];
      tick(1);
      si = 1'h0;
      take(vv[k], 1'h0, 1'h0);
      check({5'h00, disp.kind}, {5'h00, ISV_EV_SOFT});
    end
    $display("soft done");
  endtask : t_soft
  task automatic t_exc();
    logic [7:0] vv [3] = '{VEC_OVERFLOW, VEC_BREAKPOINT, VEC_RANGE};
    logic [7:0] cl [3] = '{{5'h00, ISV_CL_TRAP, 1'h0},
      {5'h00, ISV_CL_TRAP, 1'h0}, {5'h00, ISV_CL_FAULT, 1'h1}};
    for (int c = 1; c < 4; c++)
    begin
      swx = 2'(c);
      tick(1);
      swx = 2'h0;
      take(vv[c - 1], 1'h0, 1'h0);
      check({5'h00, disp.cls, disp.restart_here}, cl[c - 1]);
    end
    ev = 1'h1;
    evec = 8'h0E;
    tick(1);
    ev = 1'h0;
    take(8'h0E, 1'h1, 1'h0);
    check({5'h00, disp.cls, disp.restart_here}, cl[2]);
    mc = 1'h1;
    tick(1);
    mc = 1'h0;
    take(VEC_MACHINE_CHECK, 1'h1, 1'h0);
    check({6'h00, disp.cls}, {6'h00, ISV_CL_ABORT});
    $display("exception done");
  endtask : t_exc
  task automatic t_pins();
    logic [7:0] vv [2] = '{8'h00, 8'hC8};
    ifl = 1'h1;
    foreach (vv[k])
    begin
      pvec = vv[k];
      pdel = 4'(3 * k); // Prompt, then slow controller
      pins = 2'h1;
      for (int n = 0; n < 10 && fetch !== 1'h1; n++)
        tick(1);
      check({7'h00, fetch}, 8'h01);
      take(vv[k], 1'h0, 1'h0);
    end
    ifl = 1'h0;
    pins = 2'h1;
    watch(12);
    check({7'h00, a}, 8'h00);
    pins = 2'h0;
    tick(4);
    pins = 2'h2; // Masked, still taken
    tick(1);
    take(VEC_NMI, 1'h0, 1'h1);
    $display("pins done");
  endtask : t_pins
  task automatic t_unit();
    logic [7:0] vv [2] = '{8'h90, VEC_UNIT_MIN};
    en = 1'h1;
    ifl = 1'h1;
    pins = 2'h1;
    take(lv0, 1'h0, 1'h0);
    pins = 2'h2;
    take(lv1, 1'h0, 1'h0);
    foreach (vv[k])
    begin
      rv = 1'h1;
      rvec = vv[k];
      tick(1);
      rv = 1'h0;
      take(vv[k], 1'h0, 1'h0);
    end
    rv = 1'h1;
    rvec = 8'h0F; // Just below the legal range
    tick(1);
    rv = 1'h0;
    watch(6);
    check({6'h00, i, a}, 8'h02);
    ifl = 1'h0;
    rv = 1'h1;
    rvec = 8'h90;
    tick(1);
    rv = 1'h0;
    watch(8);
    check({7'h00, a}, 8'h00);
    $display("unit done");
  endtask : t_unit
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ==========================================
  // Main sequence
  initial
  begin
    tick(6);
    rst = 1'h0;
    tick(1);
    t_soft();
    t_exc();
    t_pins();
    t_unit();
    end_of_test();
  end
endmodule : isv_vector_select_tb
`default_nettype wire
